// file: verilog/tinv_pkg.sv
// Constants and types for the split translation-cache invalidation block.
// Assumes a 32-bit instruction word and the common two-bit privilege code.
package tinv_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode
   localparam logic [6:0] OPC_SYSTEM = 7'h73;
   localparam logic [2:0] SYS_OP_SUBCODE = 3'h0;
   localparam logic [6:0] F7_SINGLE_INV = 7'h0b;
   localparam logic [6:0] F7_ORDER_FENCE = 7'h0c;
   localparam logic [6:0] F7_GUEST_INV = 7'h13;
   localparam logic [6:0] F7_HOST_INV = 7'h33;
   localparam logic [4:0] RS2_STORE_FENCE = 5'h00;
   localparam logic [4:0] RS2_WALK_FENCE = 5'h01;

   ////////////////////////////////////////////////////////////////////////////
   // Privilege codes and invalidation targets
   localparam logic [1:0] SYS_OP_SUBCODE_USER = 2'h0;
   localparam logic [1:0] SYS_OP_SUBCODE_SUP = 2'h1;
   localparam logic [1:0] TARGET_SUP = 2'h0;
   localparam logic [1:0] TARGET_GUEST = 2'h1;
   localparam logic [1:0] TARGET_HOST = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses) and fields
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] SEQ_COUNT_OFFSET = 8'h08;
   localparam int CTRL_MTVM_BIT = 0;
   localparam int CTRL_GTVM_BIT = 1;
   localparam int CTRL_HYP_BIT = 7;
   localparam logic CTRL_MTVM_RESET = 1'b0;
   localparam logic CTRL_GTVM_RESET = 1'b0;
   localparam logic CTRL_HYP_RESET = 1'b1;
   localparam int STATUS_BUSY_BIT = 8;
   localparam int STATUS_WALK_HOLD_BIT = 9;
   localparam int STATUS_SEQ_ARMED_BIT = 10;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0]
   {
      op_none, op_single_inv, op_guest_inv, op_host_inv, op_store_fence, op_walk_fence
   } op_kind_type;

   typedef enum logic [2:0]
   {
      lvl_user, lvl_host_sup, lvl_machine, lvl_virt_user, lvl_virt_sup
   } level_type;

   typedef enum logic [2:0]
   {
      st_idle, st_room, st_drain, st_send, st_ack, st_walk
   } engine_state_type;

   typedef enum logic [1:0]
   {
      seq_none, seq_armed, seq_batch
   } seq_type;

endpackage : tinv_pkg

// file: verilog/split_translation_cache_invalidate.sv
// Split translation-cache invalidation engine with privilege checks.
// Assumes the pipeline, translation caches, store buffer and walker share mclk.
//
// How it works
// - single invalidate removes what full fence would
// - invalidations ordered only against the fences
// - store fence orders earlier stores before invalidations
// - walk fence orders invalidations before walks
// - store fence, invalidate, walk fence equal full fence
// - guest and host stage invalidations with hypervisor
// - host invalidation takes guest tag and address
// - same checks as full fences; user traps
// - machine trap bit traps supervisor single and host invalidations
// - virtual levels raise virtual instruction exceptions
// - guest trap bit traps virtual supervisor
// - ordering fences never trap on trap bits
// - fast mode pipelines invalidations, stalls at fences
// - simple mode acts as full fence
// - hypervisor option enabled by control bit seven
// - virtualization flag selects virtual levels
// - nominal privilege is the issued privilege code, machine included
// - level ranking; virtual interrupts off at user
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
module split_translation_cache_invalidate #(
   parameter int XLEN = 32,
   parameter int TAG_W = 16,
   parameter int OUT_W = 4,
   parameter bit PIPELINED = 1'b1,
   parameter bit HYP_PRESENT = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // AHB-Lite register slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Pipeline issue and completion
   input wire logic op_valid,
   input wire logic [31:0] op_insn,
   input wire logic [XLEN-1:0] op_rs1,
   input wire logic [XLEN-1:0] op_rs2,
   input wire logic [1:0] op_sys_op_subcode,
   input wire logic op_virt,
   output logic op_ready,
   output logic op_done,
   output logic op_exc_illegal,
   output logic op_exc_virtual,
   output logic seq_fence_done,
   // Current level
   output logic [1:0] nominal_sys_op_subcode,
   output logic [2:0] level_rank,
   output logic vs_irq_disable,
   // Translation caches
   output logic inv_valid,
   output logic [1:0] inv_target,
   output logic [XLEN-1:0] inv_addr,
   output logic [TAG_W-1:0] inv_tag,
   output logic inv_all_addr,
   output logic inv_all_tag,
   input wire logic inv_ready,
   input wire logic inv_ack,
   // Store buffer and walker
   input wire logic store_drained,
   output logic walk_hold
);

   if (OUT_W < 1 || OUT_W > 8 || TAG_W < 1 || TAG_W > XLEN)
   begin : bad_param_g
      $error("split_translation_cache_invalidate: unsupported parameters");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic tinv_pkg::op_kind_type decode_op(input logic [31:0] insn);
      decode_op = tinv_pkg::op_none;
      if (insn[6:0] == tinv_pkg::OPC_SYSTEM && insn[14:12] == tinv_pkg::SYS_OP_SUBCODE && insn[11:7] == 5'h00)
      begin
         case (insn[31:25])
            tinv_pkg::F7_SINGLE_INV: decode_op = tinv_pkg::op_single_inv;
            tinv_pkg::F7_GUEST_INV: decode_op = tinv_pkg::op_guest_inv;
            tinv_pkg::F7_HOST_INV: decode_op = tinv_pkg::op_host_inv;
            tinv_pkg::F7_ORDER_FENCE:
            begin
               if (insn[19:15] == 5'h00 && insn[24:20] == tinv_pkg::RS2_STORE_FENCE)
                  decode_op = tinv_pkg::op_store_fence;
               else if (insn[19:15] == 5'h00 && insn[24:20] == tinv_pkg::RS2_WALK_FENCE)
                  decode_op = tinv_pkg::op_walk_fence;
            end
            default: decode_op = tinv_pkg::op_none;
         endcase
      end
   endfunction : decode_op

   function automatic tinv_pkg::level_type level_of(input logic [1:0] sys_op_subcode, input logic virt);
      if (virt)
         level_of = (sys_op_subcode == tinv_pkg::SYS_OP_SUBCODE_USER) ? tinv_pkg::lvl_virt_user : tinv_pkg::lvl_virt_sup;
      else if (sys_op_subcode == tinv_pkg::SYS_OP_SUBCODE_USER)
         level_of = tinv_pkg::lvl_user;
      else if (sys_op_subcode == tinv_pkg::SYS_OP_SUBCODE_SUP)
         level_of = tinv_pkg::lvl_host_sup;
      else
         level_of = tinv_pkg::lvl_machine;
   endfunction : level_of

   function automatic logic [2:0] rank_of(input tinv_pkg::level_type lvl);
      case (lvl)
         tinv_pkg::lvl_machine: rank_of = 3'h4;
         tinv_pkg::lvl_host_sup: rank_of = 3'h3;
         tinv_pkg::lvl_virt_sup: rank_of = 3'h2;
         tinv_pkg::lvl_virt_user: rank_of = 3'h1;
         default: rank_of = 3'h0;
      endcase
   endfunction : rank_of

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam logic [OUT_W-1:0] OUT_MAX = '1;

   logic mtvm_reg;
   logic gtvm_reg;
   logic hyp_on_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] seq_count_reg;
   tinv_pkg::engine_state_type state_reg;
   tinv_pkg::engine_state_type state_next;
   tinv_pkg::seq_type seq_reg;
   tinv_pkg::op_kind_type cap_kind_reg;
   logic [OUT_W-1:0] out_cnt_reg;
   logic [OUT_W-1:0] out_cnt_next;
   tinv_pkg::op_kind_type kind;
   tinv_pkg::level_type lvl;
   logic accept;
   logic trap_illegal;
   logic trap_virtual;
   logic done_now;
   logic is_inv;
   logic sent;
   logic [31:0] rd_value;

   assign kind = decode_op(op_insn);
   // Virtualization only exists while the hypervisor option is on
   assign lvl = level_of(op_sys_op_subcode, op_virt && hyp_on_reg);
   assign accept = op_valid && op_ready;
   assign is_inv = kind == tinv_pkg::op_single_inv || kind == tinv_pkg::op_guest_inv || kind == tinv_pkg::op_host_inv;
   assign sent = inv_valid && inv_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Privilege checks; illegal wins over virtual

   always_comb
   begin
      trap_illegal = 1'b0;
      trap_virtual = 1'b0;
      case (kind)
         tinv_pkg::op_single_inv:
         begin
            trap_illegal = lvl == tinv_pkg::lvl_user || (lvl == tinv_pkg::lvl_host_sup && mtvm_reg);
            trap_virtual = lvl == tinv_pkg::lvl_virt_user || (lvl == tinv_pkg::lvl_virt_sup && gtvm_reg);
         end
         tinv_pkg::op_guest_inv:
         begin
            trap_illegal = !hyp_on_reg || lvl == tinv_pkg::lvl_user;
            trap_virtual = lvl == tinv_pkg::lvl_virt_user || lvl == tinv_pkg::lvl_virt_sup;
         end
         tinv_pkg::op_host_inv:
         begin
            trap_illegal = !hyp_on_reg || lvl == tinv_pkg::lvl_user || (lvl == tinv_pkg::lvl_host_sup && mtvm_reg);
            trap_virtual = lvl == tinv_pkg::lvl_virt_user || lvl == tinv_pkg::lvl_virt_sup;
         end
         tinv_pkg::op_store_fence, tinv_pkg::op_walk_fence:
         begin
            // Trap bits are ignored: trapping the invalidation alone suffices
            trap_illegal = lvl == tinv_pkg::lvl_user;
            trap_virtual = lvl == tinv_pkg::lvl_virt_user;
         end
         default:
         begin
            trap_illegal = 1'b0;
            trap_virtual = 1'b0;
         end
      endcase
      trap_virtual = trap_virtual && !trap_illegal;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Engine sequencing

   always_comb
   begin
      state_next = state_reg;
      done_now = 1'b0;
      case (state_reg)
         tinv_pkg::st_idle:
         begin
            if (accept)
            begin
               if (trap_illegal || trap_virtual || kind == tinv_pkg::op_none)
                  done_now = 1'b1;
               else if (is_inv)
                  // Fast mode never waits for stores here; simple mode is a full fence
                  state_next = PIPELINED ? tinv_pkg::st_room : tinv_pkg::st_drain;
               else if (!PIPELINED)
                  done_now = 1'b1;
               else if (kind == tinv_pkg::op_store_fence)
                  state_next = tinv_pkg::st_drain;
               else
                  state_next = tinv_pkg::st_walk;
            end
         end
         tinv_pkg::st_room:
         begin
            if (out_cnt_reg != OUT_MAX)
               state_next = tinv_pkg::st_send;
         end
         tinv_pkg::st_drain:
         begin
            if (store_drained)
            begin
               if (cap_kind_reg == tinv_pkg::op_store_fence)
               begin
                  state_next = tinv_pkg::st_idle;
                  done_now = 1'b1;
               end
               else
                  state_next = tinv_pkg::st_send;
            end
         end
         tinv_pkg::st_send:
         begin
            if (inv_ready)
            begin
               if (PIPELINED)
               begin
                  state_next = tinv_pkg::st_idle;
                  done_now = 1'b1;
               end
               else
                  state_next = tinv_pkg::st_ack;
            end
         end
         tinv_pkg::st_ack, tinv_pkg::st_walk:
         begin
            if (out_cnt_reg == '0)
            begin
               state_next = tinv_pkg::st_idle;
               done_now = 1'b1;
            end
         end
         default: state_next = tinv_pkg::st_idle;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         state_reg <= tinv_pkg::st_idle;
      else
         state_reg <= state_next;
   end

   // Completion and exception reporting, one cycle after the cause
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         op_ready <= 1'b1;
         op_done <= 1'b0;
         op_exc_illegal <= 1'b0;
         op_exc_virtual <= 1'b0;
      end
      else
      begin
         op_ready <= state_next == tinv_pkg::st_idle;
         op_done <= done_now;
         op_exc_illegal <= accept && trap_illegal;
         op_exc_virtual <= accept && trap_virtual;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Captured operation and the invalidation request

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cap_kind_reg <= tinv_pkg::op_none;
         inv_target <= tinv_pkg::TARGET_SUP;
         inv_addr <= '0;
         inv_tag <= '0;
         inv_all_addr <= 1'b0;
         inv_all_tag <= 1'b0;
      end
      else if (accept)
      begin
         cap_kind_reg <= kind;
         // Same operand meaning as the matching full fence: x0 widens to all
         inv_addr <= op_rs1;
         inv_tag <= op_rs2[TAG_W-1:0];
         inv_all_addr <= op_insn[19:15] == 5'h00;
         inv_all_tag <= op_insn[24:20] == 5'h00;
         case (kind)
            tinv_pkg::op_guest_inv: inv_target <= tinv_pkg::TARGET_GUEST;
            tinv_pkg::op_host_inv: inv_target <= tinv_pkg::TARGET_HOST;
            default: inv_target <= tinv_pkg::TARGET_SUP;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         inv_valid <= 1'b0;
      else
         inv_valid <= state_next == tinv_pkg::st_send;
   end

   // Outstanding invalidations; an ack with none outstanding is ignored
   always_comb
   begin
      out_cnt_next = out_cnt_reg;
      if (sent && !(inv_ack && out_cnt_reg != '0))
         out_cnt_next = out_cnt_reg + 1'b1;
      else if (!sent && inv_ack && out_cnt_reg != '0)
         out_cnt_next = out_cnt_reg - 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_cnt_reg <= '0;
         walk_hold <= 1'b0;
      end
      else
      begin
         out_cnt_reg <= out_cnt_next;
         // Conservative: walks wait whenever any invalidation is in flight
         walk_hold <= out_cnt_next != '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fence-invalidate-fence tracking

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         seq_reg <= tinv_pkg::seq_none;
         seq_fence_done <= 1'b0;
         seq_count_reg <= 32'h0;
      end
      else
      begin
         seq_fence_done <= 1'b0;
         if (done_now && state_reg != tinv_pkg::st_idle)
         begin
            case (cap_kind_reg)
               tinv_pkg::op_store_fence: seq_reg <= tinv_pkg::seq_armed;
               tinv_pkg::op_walk_fence:
               begin
                  seq_reg <= tinv_pkg::seq_none;
                  seq_fence_done <= seq_reg == tinv_pkg::seq_batch;
                  if (seq_reg == tinv_pkg::seq_batch)
                     seq_count_reg <= seq_count_reg + 32'h1;
               end
               default:
               begin
                  if (seq_reg != tinv_pkg::seq_none)
                     seq_reg <= tinv_pkg::seq_batch;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Current level outputs

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         nominal_sys_op_subcode <= 2'h3;
         level_rank <= 3'h4;
         vs_irq_disable <= 1'b0;
      end
      else
      begin
         nominal_sys_op_subcode <= op_sys_op_subcode;
         level_rank <= rank_of(lvl);
         vs_irq_disable <= lvl == tinv_pkg::lvl_user;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite register slave, zero wait states, always OKAY

   always_comb
   begin
      rd_value = 32'h0;
      case (haddr)
         tinv_pkg::CTRL_OFFSET:
         begin
            rd_value[tinv_pkg::CTRL_MTVM_BIT] = mtvm_reg;
            rd_value[tinv_pkg::CTRL_GTVM_BIT] = gtvm_reg;
            rd_value[tinv_pkg::CTRL_HYP_BIT] = hyp_on_reg;
         end
         tinv_pkg::STATUS_OFFSET:
         begin
            rd_value[OUT_W-1:0] = out_cnt_reg;
            rd_value[tinv_pkg::STATUS_BUSY_BIT] = state_reg != tinv_pkg::st_idle;
            rd_value[tinv_pkg::STATUS_WALK_HOLD_BIT] = walk_hold;
            rd_value[tinv_pkg::STATUS_SEQ_ARMED_BIT] = seq_reg != tinv_pkg::seq_none;
         end
         tinv_pkg::SEQ_COUNT_OFFSET: rd_value = seq_count_reg;
         default: rd_value = 32'h0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_reg <= hsel && hready && htrans == tinv_pkg::HTRANS_NONSEQ && hwrite;
         if (hsel && hready && htrans == tinv_pkg::HTRANS_NONSEQ)
            wr_addr_reg <= haddr;
         if (hsel && hready && htrans == tinv_pkg::HTRANS_NONSEQ && !hwrite)
            hrdata <= rd_value;
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mtvm_reg <= tinv_pkg::CTRL_MTVM_RESET;
         gtvm_reg <= tinv_pkg::CTRL_GTVM_RESET;
         hyp_on_reg <= HYP_PRESENT && tinv_pkg::CTRL_HYP_RESET;
      end
      else if (wr_pend_reg && wr_addr_reg == tinv_pkg::CTRL_OFFSET)
      begin
         mtvm_reg <= hwdata[tinv_pkg::CTRL_MTVM_BIT];
         gtvm_reg <= hwdata[tinv_pkg::CTRL_GTVM_BIT];
         // Kept writable so the option can be switched off
         hyp_on_reg <= HYP_PRESENT && hwdata[tinv_pkg::CTRL_HYP_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   user_inv_trap_a: assert property (@(posedge mclk) disable iff (!rst_b)
      accept && is_inv && lvl == tinv_pkg::lvl_user |=> op_done && op_exc_illegal && !op_exc_virtual)
      else $error("invalidation at user level not illegal");

   mtvm_inv_trap_a: assert property (@(posedge mclk) disable iff (!rst_b)
      accept && mtvm_reg && lvl == tinv_pkg::lvl_host_sup && hyp_on_reg &&
      (kind == tinv_pkg::op_single_inv || kind == tinv_pkg::op_host_inv) |=> op_exc_illegal)
      else $error("machine trap bit ignored");

   virt_inv_trap_a: assert property (@(posedge mclk) disable iff (!rst_b)
      accept && hyp_on_reg && (kind == tinv_pkg::op_guest_inv || kind == tinv_pkg::op_host_inv) &&
      (lvl == tinv_pkg::lvl_virt_sup || lvl == tinv_pkg::lvl_virt_user) |=> op_exc_virtual && !op_exc_illegal)
      else $error("virtual level not virtual exception");

   gtvm_inv_trap_a: assert property (@(posedge mclk) disable iff (!rst_b)
      accept && gtvm_reg && kind == tinv_pkg::op_single_inv && lvl == tinv_pkg::lvl_virt_sup |=> op_exc_virtual)
      else $error("guest trap bit ignored");

   fence_no_trap_a: assert property (@(posedge mclk) disable iff (!rst_b)
      accept && (kind == tinv_pkg::op_store_fence || kind == tinv_pkg::op_walk_fence) &&
      (lvl == tinv_pkg::lvl_host_sup || lvl == tinv_pkg::lvl_virt_sup) |=> !op_exc_illegal && !op_exc_virtual)
      else $error("ordering fence trapped");

   hyp_off_trap_a: assert property (@(posedge mclk) disable iff (!rst_b)
      accept && !hyp_on_reg && (kind == tinv_pkg::op_guest_inv || kind == tinv_pkg::op_host_inv) |=> op_exc_illegal)
      else $error("hypervisor invalidation with option off");

   store_order_a: assert property (@(posedge mclk) disable iff (!rst_b)
      state_reg == tinv_pkg::st_drain && !store_drained |=> !inv_valid && !op_done)
      else $error("drain wait skipped");

   walk_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      state_reg == tinv_pkg::st_walk && out_cnt_reg != '0 |-> walk_hold ##1 !op_done)
      else $error("walk fence finished with invalidations pending");

   inv_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      inv_valid && !inv_ready |=> inv_valid && $stable(inv_addr) && $stable(inv_tag) && $stable(inv_target))
      else $error("invalidation request changed while stalled");

   seq_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
      seq_fence_done |-> op_done && seq_reg == tinv_pkg::seq_none && $past(cap_kind_reg) == tinv_pkg::op_walk_fence)
      else $error("sequence completion without walk fence");

   vs_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
      op_sys_op_subcode == tinv_pkg::SYS_OP_SUBCODE_USER && !op_virt |=> vs_irq_disable && level_rank == 3'h0)
      else $error("virtual interrupts not disabled at user");

endmodule : split_translation_cache_invalidate

// file: verif/tcache_model.sv
// Translation caches and store buffer answering invalidation requests.
// Assumes the shared mclk and rst_b of the block.
module tcache_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Invalidation handshake and store drain
   input wire logic inv_valid,
   output logic inv_ready,
   output logic inv_ack,
   output logic store_drained
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] lag_reg;
   logic [1:0] beat_reg;
   // Ready comes a cycle late so the request must hold
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         inv_ready <= 1'b0;
         lag_reg <= 3'h0;
         beat_reg <= 2'h0;
      end
      else
      begin
         inv_ready <= inv_valid && !inv_ready;
         lag_reg <= {lag_reg[1:0], inv_ready};
         beat_reg <= beat_reg + 2'h1;
      end
   end
   // Late ack keeps an invalidation in flight when a walk fence arrives
   assign inv_ack = lag_reg[2];
   // Stores drain only in half of each four-cycle beat, so store fences must wait
   assign store_drained = beat_reg[1];
endmodule : tcache_model

// file: verif/split_translation_cache_invalidate_tb_top.sv
// Bench for the split invalidation block: bus and operation tasks.
// Assumes the cache model answers every invalidation.
module split_translation_cache_invalidate_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, op_valid = 1'b0, op_virt = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0, op_sys_op_subcode = 2'h3;
   logic [31:0] hwdata = 32'h0, op_insn = 32'h0, op_rs1 = 32'habcde000, op_rs2 = 32'h00000042, rd, sent_addr;
   logic [19:0] sent_tt;
   logic hreadyout, hresp, op_ready, op_done, ill, virt, seq_done, seq_last, inv_valid, inv_ready, inv_ack, drained;
   logic walk_hold, vs_off, all_a, all_t;
   logic [31:0] hrdata, inv_addr;
   logic [1:0] nominal_sys_op_subcode, inv_target;
   logic [2:0] level_rank;
   logic [15:0] inv_tag;
   int err_total = 0, checks_done = 0;
   always #10 mclk = ~mclk;
   split_translation_cache_invalidate i_split_translation_cache_invalidate (.mclk(mclk), .rst_b(rst_b),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .op_valid(op_valid),
      .op_insn(op_insn), .op_rs1(op_rs1), .op_rs2(op_rs2), .op_sys_op_subcode(op_sys_op_subcode), .op_virt(op_virt),
      .op_ready(op_ready), .op_done(op_done), .op_exc_illegal(ill), .op_exc_virtual(virt),
      .seq_fence_done(seq_done), .nominal_sys_op_subcode(nominal_sys_op_subcode), .level_rank(level_rank), .vs_irq_disable(vs_off),
      .inv_valid(inv_valid), .inv_target(inv_target), .inv_addr(inv_addr), .inv_tag(inv_tag),
      .inv_all_addr(all_a), .inv_all_tag(all_t), .inv_ready(inv_ready), .inv_ack(inv_ack), .store_drained(drained),
      .walk_hold(walk_hold));
   tcache_model i_tcache_model (.mclk(mclk), .rst_b(rst_b), .inv_valid(inv_valid), .inv_ready(inv_ready),
      .inv_ack(inv_ack), .store_drained(drained));
   always @(posedge mclk)
      if (inv_valid && inv_ready)
      begin
         sent_addr <= inv_addr;
         sent_tt <= {all_a, all_t, inv_target, inv_tag};
      end
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for an edge sampling 0 hreadyout, 1 op_ready, 2 op_done
   task automatic wait_on(input int sel);
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while ((sel == 0 ? hreadyout : sel == 1 ? op_ready : op_done) !== 1'b1 && n < 60);
      if (n == 60 && (sel == 0 ? hreadyout : sel == 1 ? op_ready : op_done) !== 1'b1)
      begin
         err_total++;
         conclude();
      end
   endtask : wait_on
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= tinv_pkg::HTRANS_NONSEQ;
      wait_on(0);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_on(0);
      rd = hrdata;
   endtask : bus
   task automatic op(input logic [6:0] f7, input logic [4:0] rs2, input logic [1:0] pr, input logic v,
      input logic [1:0] ex);
      op_insn <= {f7, rs2, (f7 == tinv_pkg::F7_ORDER_FENCE) ? 5'h00 : 5'h05, tinv_pkg::SYS_OP_SUBCODE, 5'h00,
         tinv_pkg::OPC_SYSTEM};
      op_sys_op_subcode <= pr;
      op_virt <= v;
      op_valid <= 1'b1;
      wait_on(1);
      op_valid <= 1'b0;
      wait_on(2);
      seq_last = seq_done;
      chk(32'({ill, virt}), 32'(ex));
   endtask : op
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      bus(1'b0, tinv_pkg::CTRL_OFFSET, 32'h0);
      chk(rd, 32'h00000080);
      chk(32'(hresp), 32'h0);
      bus(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      $display("test registers done");
      op(tinv_pkg::F7_ORDER_FENCE, tinv_pkg::RS2_STORE_FENCE, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b0, 2'h0);
      op(tinv_pkg::F7_SINGLE_INV, 5'h00, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b0, 2'h0);
      chk(sent_addr, op_rs1);
      chk(32'(sent_tt), 32'h00040042);
      op(tinv_pkg::F7_HOST_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b0, 2'h0);
      chk(32'(sent_tt), 32'h00020042);
      op(tinv_pkg::F7_ORDER_FENCE, tinv_pkg::RS2_WALK_FENCE, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b0, 2'h0);
      chk(32'({seq_last, walk_hold}), 32'h2);
      bus(1'b0, tinv_pkg::SEQ_COUNT_OFFSET, 32'h0);
      chk(rd, 32'h1);
      $display("test batch done");
      op(tinv_pkg::F7_SINGLE_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_USER, 1'b0, 2'h2);
      bus(1'b1, tinv_pkg::CTRL_OFFSET, 32'h00000081);
      op(tinv_pkg::F7_SINGLE_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b0, 2'h2);
      op(tinv_pkg::F7_HOST_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b0, 2'h2);
      op(tinv_pkg::F7_ORDER_FENCE, tinv_pkg::RS2_STORE_FENCE, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b0, 2'h0);
      op(tinv_pkg::F7_GUEST_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b1, 2'h1);
      op(tinv_pkg::F7_SINGLE_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_USER, 1'b1, 2'h1);
      bus(1'b1, tinv_pkg::CTRL_OFFSET, 32'h00000082);
      op(tinv_pkg::F7_SINGLE_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b1, 2'h1);
      chk(32'({nominal_sys_op_subcode, level_rank}), 32'h0a);
      bus(1'b1, tinv_pkg::CTRL_OFFSET, 32'h0);
      op(tinv_pkg::F7_GUEST_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_SUP, 1'b0, 2'h2);
      op(tinv_pkg::F7_SINGLE_INV, 5'h06, tinv_pkg::SYS_OP_SUBCODE_USER, 1'b0, 2'h2);
      chk(32'(vs_off), 32'h1);
      $display("test traps done");
      conclude();
   end
endmodule : split_translation_cache_invalidate_tb_top
